// File: logic/serial_port_uart_pkg.sv
// What this block does
// [RULE1] mode 00: shift register clocked at core clock divided by twelve
// [RULE2] mode 01: 8-bit UART timed by the selectable baud source
// [RULE3] mode 10: 9-bit UART at clock/64, or clock/32 with baud double set
// [RULE4] mode 11: 9-bit UART timed by the selectable baud source
// [RULE5] reception only while the receive enable bit 4 is one
// [RULE6] modes 2 and 3 send control bit 3 as the ninth bit
// [RULE7] modes 2 and 3 store the ninth received bit in control bit 2
// [RULE8] tx done bit 1 set at end of bit 8 (mode 0) or stop start
// [RULE9] rx done bit 0 set at end of bit 8 (mode 0) or stop middle
// [RULE10] writing the data buffer loads it and starts a transmission
// [RULE11] reading the data buffer returns the separate receive buffer
// [RULE12] baud source bit 7 in modes 1 and 3: 1 internal, 0 timer 1
// [RULE13] timer 1 source: rate is 2^double times overflow rate over 32
// [RULE14] internal source: rate is 2^double clock over 64*(1024-reload)
// [RULE15] reload value is low register plus two low bits of high register
// [RULE16] all bit timing derives from the core clock only; with the timer 1 source the tick comes from timer1Overflow instead
// [RULE17] multiprocessor enable in 9-bit modes accepts only ninth bit one
// [RULE18] frames: low start, data LSB first, optional ninth, high stop, idle high
package serial_port_uart_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_DATA = 8'h99;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'haa;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hba;
  localparam logic [7:0] ADDR_BAUD_SELECT = 8'hd8;
  localparam logic [7:0] ADDR_BAUD_DOUBLE = 8'hf7;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hf8;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hf9;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_RELOAD_LOW = 8'hd9;
  localparam logic [7:0] RST_RELOAD_HIGH = 8'h03;
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_MPE = 5;
  localparam int BIT_REN = 4;
  localparam int BIT_TB8 = 3;
  localparam int BIT_RB8 = 2;
  localparam int BIT_TI = 1;
  localparam int BIT_RI = 0;
  localparam int BIT_BAUD_GEN = 7;
  localparam int BIT_DOUBLE = 7;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam logic [3:0] SHIFT_LAST = 4'hb;
  localparam logic [3:0] SHIFT_HALF = 4'h6;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] PRE_SLOW = 2'h3;
  localparam logic [1:0] PRE_FAST = 2'h1;
  localparam logic [9:0] RELOAD_TOP = 10'h3ff;
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00, MODE_UART8 = 2'b01, MODE_UART9_FIXED = 2'b10, MODE_UART9_VAR = 2'b11
  } mode_type;
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100, TX_NINTH = 5'b01000, TX_STOP = 5'b10000
  } tx_state_type;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100, RX_NINTH = 5'b01000, RX_STOP = 5'b10000
  } rx_state_type;
endpackage

// File: logic/serial_port_uart.sv
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
module serial_port_uart import serial_port_uart_pkg::*; (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic timer1Overflow,
  input wire logic rxdIn,
  output logic rxdOut,
  output logic rxdOe,
  output logic txdOut,
  output logic irq
);
  logic [7:0] control;
  logic [7:0] rxBuffer;
  logic [7:0] reloadLow;
  logic [7:0] reloadHigh;
  logic baudSelect;
  logic baudDouble;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  mode_type mode;
  logic varMode;
  logic nineBit;
  logic [9:0] reloadValue;
  logic wrCtl;
  logic wrData;
  logic [1:0] preCnt;
  logic preDone;
  logic [9:0] relCnt;
  logic t1Half;
  logic sampleTick;
  logic syncBusy;
  logic syncRx;
  logic [3:0] syncPhase;
  logic [2:0] syncBits;
  logic syncEnd;
  logic syncStartRx;
  tx_state_type txState;
  logic [3:0] txTick;
  logic [2:0] txBit;
  logic [7:0] txShift;
  logic txNinthBit;
  logic txLine;
  logic txBitEnd;
  logic asyncTxDone;
  logic txDoneSet;
  rx_state_type rxState;
  logic [3:0] rxTick;
  logic [2:0] rxBit;
  logic [7:0] rxShift;
  logic rxNinthLatch;
  logic rxPrev;
  logic rxSampleNow;
  logic rxAccept;
  logic rxStore;
  logic rxNinth;

  assign mode = mode_type'(control[BIT_MODE_HI:BIT_MODE_LO]);
  assign varMode = control[BIT_MODE_LO];
  assign nineBit = control[BIT_MODE_HI];
  assign reloadValue = {reloadHigh[1:0], reloadLow}; // RULE15
  assign wrCtl = regWrite && regAddr == ADDR_CONTROL;
  assign wrData = regWrite && regAddr == ADDR_DATA;

  // register file
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reloadLow <= RST_RELOAD_LOW;
      reloadHigh <= RST_RELOAD_HIGH;
      baudSelect <= 1'b0;
      baudDouble <= 1'b0;
      irqMask <= 2'h0;
    end else if (regWrite) begin
      if (regAddr == ADDR_RELOAD_LOW) begin
        reloadLow <= regWdata;
      end else if (regAddr == ADDR_RELOAD_HIGH) begin
        reloadHigh <= regWdata;
      end else if (regAddr == ADDR_BAUD_SELECT) begin
        baudSelect <= regWdata[BIT_BAUD_GEN];
      end else if (regAddr == ADDR_BAUD_DOUBLE) begin
        baudDouble <= regWdata[BIT_DOUBLE];
      end else if (regAddr == ADDR_IRQ_MASK) begin
        irqMask <= regWdata[1:0];
      end
    end
  end

  // hardware set beats a software write in the same cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      control <= RST_CONTROL;
    end else begin
      if (wrCtl) begin
        control[BIT_MODE_HI:BIT_TB8] <= regWdata[BIT_MODE_HI:BIT_TB8];
      end
      if (rxStore) begin
        control[BIT_RB8] <= rxNinth; // RULE7
      end else if (wrCtl) begin
        control[BIT_RB8] <= regWdata[BIT_RB8];
      end
      if (txDoneSet) begin
        control[BIT_TI] <= 1'b1; // RULE8
      end else if (wrCtl) begin
        control[BIT_TI] <= regWdata[BIT_TI];
      end
      if (rxStore) begin
        control[BIT_RI] <= 1'b1; // RULE9
      end else if (wrCtl) begin
        control[BIT_RI] <= regWdata[BIT_RI];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irqStatus <= 2'h0;
    end else begin
      irqStatus[IRQ_RX] <= rxStore || (irqStatus[IRQ_RX] &&
        !(regWrite && regAddr == ADDR_IRQ_STATUS && regWdata[IRQ_RX]));
      irqStatus[IRQ_TX] <= txDoneSet || (irqStatus[IRQ_TX] &&
        !(regWrite && regAddr == ADDR_IRQ_STATUS && regWdata[IRQ_TX]));
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      regRdata <= 8'h00;
    end else if (!regRead) begin
      regRdata <= 8'h00;
    end else if (regAddr == ADDR_CONTROL) begin
      regRdata <= control;
    end else if (regAddr == ADDR_DATA) begin
      regRdata <= rxBuffer; // RULE11
    end else if (regAddr == ADDR_RELOAD_LOW) begin
      regRdata <= reloadLow;
    end else if (regAddr == ADDR_RELOAD_HIGH) begin
      regRdata <= reloadHigh;
    end else if (regAddr == ADDR_BAUD_SELECT) begin
      regRdata <= {baudSelect, 7'h00};
    end else if (regAddr == ADDR_BAUD_DOUBLE) begin
      regRdata <= {baudDouble, 7'h00};
    end else if (regAddr == ADDR_IRQ_STATUS) begin
      regRdata <= {6'h00, irqStatus};
    end else if (regAddr == ADDR_IRQ_MASK) begin
      regRdata <= {6'h00, irqMask};
    end else begin
      regRdata <= 8'h00;
    end
  end

  // sixteen-times oversampling tick, from core_clk, or from timer1Overflow when timer 1 is the baud source
  assign preDone = preCnt == (baudDouble ? PRE_FAST : PRE_SLOW); // RULE3 RULE14

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      preCnt <= 2'h0;
    end else begin
      preCnt <= preDone ? 2'h0 : preCnt + 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // start on the reset reload value so the generator keeps its rate right after reset
      relCnt <= {RST_RELOAD_HIGH[1:0], RST_RELOAD_LOW};
    end else if (preDone) begin
      relCnt <= (relCnt == RELOAD_TOP) ? reloadValue : relCnt + 10'h001; // RULE14
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      t1Half <= 1'b0;
    end else if (timer1Overflow) begin
      t1Half <= !t1Half;
    end
  end

  always_comb begin
    if (!varMode) begin
      sampleTick = preDone; // RULE3 RULE16
    end else if (baudSelect) begin
      sampleTick = preDone && relCnt == RELOAD_TOP; // RULE12 RULE2 RULE4
    end else begin
      sampleTick = timer1Overflow && (baudDouble || t1Half); // RULE13
    end
  end

  // mode 0 engine: one shift clock every twelve core clocks
  assign syncEnd = syncBusy && syncPhase == SHIFT_LAST;
  assign syncStartRx = mode == MODE_SHIFT && control[BIT_REN] && !control[BIT_RI] &&
    !syncBusy && !wrData; // RULE5

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      syncBusy <= 1'b0;
      syncRx <= 1'b0;
      syncPhase <= 4'h0;
      syncBits <= 3'h0;
    end else if (wrData && mode == MODE_SHIFT) begin
      syncBusy <= 1'b1;
      syncRx <= 1'b0;
      syncPhase <= 4'h0;
      syncBits <= 3'h0;
    end else if (syncStartRx) begin
      syncBusy <= 1'b1;
      syncRx <= 1'b1;
      syncPhase <= 4'h0;
      syncBits <= 3'h0;
    end else if (syncBusy) begin
      syncPhase <= syncEnd ? 4'h0 : syncPhase + 4'h1; // RULE1
      if (syncEnd) begin
        syncBits <= syncBits + 3'h1;
        if (syncBits == BIT_LAST) begin
          syncBusy <= 1'b0;
        end
      end
    end
  end

  // asynchronous transmitter
  assign txBitEnd = sampleTick && txTick == TICK_LAST;
  assign asyncTxDone = txBitEnd && ((txState == TX_DATA && txBit == BIT_LAST && !nineBit) ||
    txState == TX_NINTH);
  assign txDoneSet = asyncTxDone || (syncEnd && !syncRx && syncBits == BIT_LAST); // RULE8

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      txState <= TX_IDLE;
      txTick <= 4'h0;
      txBit <= 3'h0;
      txShift <= RST_DATA;
      txNinthBit <= 1'b0;
      txLine <= 1'b1;
    end else if (wrData) begin
      txShift <= regWdata; // RULE10
      txNinthBit <= control[BIT_TB8]; // RULE6
      txTick <= 4'h0;
      txBit <= 3'h0;
      if (mode != MODE_SHIFT) begin
        txState <= TX_START;
        txLine <= 1'b0; // RULE18
      end
    end else if (syncEnd && !syncRx) begin
      txShift <= {1'b0, txShift[7:1]};
    end else begin
      if (sampleTick) begin
        txTick <= txTick + 4'h1;
      end
      case (txState)
        TX_START: begin
          if (txBitEnd) begin
            txState <= TX_DATA;
            txLine <= txShift[0];
            txShift <= {1'b0, txShift[7:1]};
          end
        end
        TX_DATA: begin
          if (txBitEnd) begin
            txBit <= txBit + 3'h1;
            if (txBit != BIT_LAST) begin
              txLine <= txShift[0];
              txShift <= {1'b0, txShift[7:1]};
            end else if (nineBit) begin
              txState <= TX_NINTH;
              txLine <= txNinthBit; // RULE6
            end else begin
              txState <= TX_STOP;
              txLine <= 1'b1;
            end
          end
        end
        TX_NINTH: begin
          if (txBitEnd) begin
            txState <= TX_STOP;
            txLine <= 1'b1; // RULE18
          end
        end
        TX_STOP: begin
          if (txBitEnd) begin
            txState <= TX_IDLE;
          end
        end
        default: begin
          txState <= TX_IDLE;
          txLine <= 1'b1;
        end
      endcase
    end
  end

  // pin drive; in mode 0 the transmit pin carries the shift clock
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      txdOut <= 1'b1;
      rxdOut <= 1'b1;
      rxdOe <= 1'b0;
    end else if (mode == MODE_SHIFT) begin
      txdOut <= !syncBusy || syncPhase >= SHIFT_HALF; // RULE1
      rxdOut <= txShift[0];
      rxdOe <= syncBusy && !syncRx;
    end else begin
      txdOut <= txLine;
      rxdOut <= 1'b1;
      rxdOe <= 1'b0;
    end
  end

  // asynchronous receiver
  assign rxSampleNow = sampleTick && rxTick == TICK_LAST;
  assign rxAccept = !control[BIT_RI] && rxdIn &&
    (!control[BIT_MPE] || !nineBit || rxNinthLatch); // RULE17 RULE18
  assign rxNinth = nineBit ? rxNinthLatch : rxdIn;
  assign rxStore = (rxState == RX_STOP && rxSampleNow && rxAccept) ||
    (syncEnd && syncRx && syncBits == BIT_LAST); // RULE9

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rxPrev <= 1'b1;
    end else begin
      rxPrev <= rxdIn;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rxState <= RX_IDLE;
      rxTick <= 4'h0;
      rxBit <= 3'h0;
      rxShift <= 8'h00;
      rxNinthLatch <= 1'b0;
      rxBuffer <= RST_DATA;
    end else if (mode == MODE_SHIFT) begin
      rxState <= RX_IDLE;
      if (syncEnd && syncRx) begin
        rxShift <= {rxdIn, rxShift[7:1]};
        if (syncBits == BIT_LAST) begin
          rxBuffer <= {rxdIn, rxShift[7:1]};
        end
      end
    end else begin
      if (sampleTick) begin
        rxTick <= rxTick + 4'h1;
      end
      case (rxState)
        RX_IDLE: begin
          if (control[BIT_REN] && rxPrev && !rxdIn) begin // RULE5
            rxState <= RX_START;
            rxTick <= 4'h0;
            rxBit <= 3'h0;
          end
        end
        RX_START: begin
          if (sampleTick && rxTick == TICK_MID) begin
            rxTick <= 4'h0;
            rxState <= rxdIn ? RX_IDLE : RX_DATA; // RULE18
          end
        end
        RX_DATA: begin
          if (rxSampleNow) begin
            rxShift <= {rxdIn, rxShift[7:1]};
            rxBit <= rxBit + 3'h1;
            if (rxBit == BIT_LAST) begin
              rxState <= nineBit ? RX_NINTH : RX_STOP;
            end
          end
        end
        RX_NINTH: begin
          if (rxSampleNow) begin
            rxNinthLatch <= rxdIn; // RULE7
            rxState <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rxSampleNow) begin
            rxState <= RX_IDLE;
            if (rxAccept) begin
              rxBuffer <= rxShift;
            end
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_shift_clock_period: assert property ( // RULE1
    (syncBusy && syncPhase == 4'h0 && syncBits != BIT_LAST) |-> ##12 (syncPhase == 4'h0 && syncBusy))
    else $error("shift clock period is not twelve core clocks");
  chk_rx_enable_gate: assert property ( // RULE5
    (rxState == RX_IDLE && !control[BIT_REN]) |=> rxState == RX_IDLE && !(syncBusy && syncRx && $rose(syncBusy)))
    else $error("reception started while disabled");
  chk_ninth_bit_sent: assert property ( // RULE6
    (mode != MODE_SHIFT && $rose(txState == TX_NINTH)) |-> txLine == txNinthBit ##2 txdOut == txNinthBit)
    else $error("ninth bit on the line differs from tb8");
  chk_tx_done_flag: assert property ( // RULE8
    txDoneSet |=> control[BIT_TI] && irqStatus[IRQ_TX])
    else $error("tx done flag not set");
  chk_rx_done_flag: assert property ( // RULE9
    rxStore |=> control[BIT_RI] && control[BIT_RB8] == $past(rxNinth))
    else $error("rx done flag or ninth bit not stored");
  chk_write_starts_tx: assert property ( // RULE10
    (wrData && mode != MODE_SHIFT) |=> txState == TX_START && !txLine ##2 !txdOut)
    else $error("write did not start a frame");
  chk_read_rx_buffer: assert property ( // RULE11
    (regRead && regAddr == ADDR_DATA) |=> regRdata == $past(rxBuffer))
    else $error("data read did not return receive buffer");
  chk_fixed_rate: assert property ( // RULE3
    (!varMode && !baudDouble && preCnt == 2'h0) |-> (baudDouble || !preDone) [*3] ##1 (baudDouble || preDone))
    else $error("fixed rate divider wrong");
  chk_mpe_filter: assert property ( // RULE17
    (rxStore && nineBit && control[BIT_MPE] && mode != MODE_SHIFT) |-> rxNinthLatch)
    else $error("multiprocessor frame accepted with ninth bit zero");

  cov_shift_tx: cover property (syncEnd && !syncRx && syncBits == BIT_LAST);
  cov_async_rx: cover property (rxState == RX_STOP && rxSampleNow && rxAccept);
  cov_nine_tx: cover property (asyncTxDone && nineBit);
endmodule

// File: verif/serial_peer.sv
`timescale 1ns/10ps
module serial_peer (
  input wire logic core_clk,
  input wire logic lineIn,
  output logic lineOut
);
  initial lineOut = 1'h1;

  // f holds the frame in line order: start, data lsb first, optional ninth, stop
  task automatic send_frame(input logic [10:0] f, input int nb, input int period);
    for (int i = 0; i < nb + 2; i++) begin
      @(posedge core_clk);
      lineOut <= f[i];
      repeat (period - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    lineOut <= 1'h1;
  endtask

  // waits for a start edge, then samples each bit in its middle
  task automatic recv_frame(input int nb, input int period, output logic [10:0] f);
    int n;
    f = 'x;
    n = 0;
    while (lineIn !== 1'h0 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    if (n < 4000) begin
      f = '0;
      repeat (period / 2) @(posedge core_clk);
      for (int i = 0; i < nb + 2; i++) begin
        f[i] = lineIn;
        repeat (period) @(posedge core_clk);
      end
    end
  endtask
endmodule

// File: verif/serial_port_uart_tb_top.sv
`timescale 1ns/10ps
module serial_port_uart_tb_top import serial_port_uart_pkg::*;;
  logic core_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'h0;
  logic regRead = 1'h0;
  logic timer1Overflow = 1'h0;
  logic ovfRun = 1'h0;
  logic [1:0] ovfCnt = 2'h0;
  logic [7:0] regRdata;
  logic rxdIn;
  logic rxdOut;
  logic rxdOe;
  logic txdOut;
  logic irq;
  logic peerLine;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;

  always #12.5 core_clk = ~core_clk;
  // the receive pin carries the block's drive in mode 0 transmit, else the peer
  assign rxdIn = rxdOe ? rxdOut : peerLine;

  serial_port_uart uut (.core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .timer1Overflow(timer1Overflow),
    .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe), .txdOut(txdOut), .irq(irq));
  serial_peer peer (.core_clk(core_clk), .lineIn(txdOut), .lineOut(peerLine));

  always @(posedge core_clk) begin
    ovfCnt <= ovfCnt + 2'h1;
    timer1Overflow <= ovfRun && (ovfCnt == 2'h3);
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'h1;
    @(posedge core_clk);
    regWrite <= 1'h0;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge core_clk);
    regRead <= 1'h0;
    #1;
    check(name, regRdata, exp);
  endtask

  task automatic t_regs;
    rdchk("control reset", ADDR_CONTROL, RST_CONTROL);
    rdchk("buffer reset", ADDR_DATA, RST_DATA);
    rdchk("reload low reset", ADDR_RELOAD_LOW, RST_RELOAD_LOW);
    rdchk("reload high reset", ADDR_RELOAD_HIGH, RST_RELOAD_HIGH);
    wr(ADDR_BAUD_SELECT, 8'hff);
    rdchk("select bits", ADDR_BAUD_SELECT, 8'h80);
    wr(8'h55, 8'h12);
    rdchk("unmapped", 8'h55, 8'h00);
    $display("test registers done");
  endtask

  task automatic t_mode2_tx;
    logic [10:0] f;
    wr(ADDR_BAUD_DOUBLE, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h03);
    wr(ADDR_CONTROL, 8'h88);
    wr(ADDR_DATA, 8'ha5);
    peer.recv_frame(9, 64, f);
    check("mode2 frame", f, {1'h1, 1'h1, 8'ha5, 1'h0});
    rdchk("tx done", ADDR_CONTROL, 8'h8a);
    check("irq tx", irq, 1'h1);
    wr(ADDR_IRQ_STATUS, 8'h02);
    repeat (2) @(posedge core_clk);
    #1;
    check("irq clear", irq, 1'h0);
    wr(ADDR_CONTROL, 8'h80);
    $display("test mode2 transmit done");
  endtask

  task automatic t_mode2_rx;
    wr(ADDR_BAUD_DOUBLE, 8'h80);
    peer.send_frame({1'h1, 1'h1, 8'h3c, 1'h0}, 9, 32);
    rdchk("ren off", ADDR_CONTROL, 8'h80);
    wr(ADDR_CONTROL, 8'h90);
    peer.send_frame({1'h1, 1'h1, 8'h3c, 1'h0}, 9, 32);
    rdchk("rx done rb8", ADDR_CONTROL, 8'h95);
    check("irq rx", irq, 1'h1);
    rdchk("rx buffer", ADDR_DATA, 8'h3c);
    wr(ADDR_CONTROL, 8'hb0);
    peer.send_frame({1'h1, 1'h0, 8'h66, 1'h0}, 9, 32);
    rdchk("mpe drop", ADDR_CONTROL, 8'hb0);
    peer.send_frame({1'h1, 1'h1, 8'h66, 1'h0}, 9, 32);
    rdchk("mpe accept", ADDR_CONTROL, 8'hb5);
    rdchk("mpe buffer", ADDR_DATA, 8'h66);
    wr(ADDR_IRQ_STATUS, 8'h03);
    wr(ADDR_CONTROL, 8'h00);
    $display("test mode2 receive done");
  endtask

  task automatic t_mode1_int;
    logic [10:0] f;
    wr(ADDR_BAUD_DOUBLE, 8'h00);
    wr(ADDR_BAUD_SELECT, 8'h80);
    wr(ADDR_RELOAD_LOW, 8'hff);
    wr(ADDR_RELOAD_HIGH, 8'h03);
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_CONTROL, 8'h40);
    // let the reload counter reach its top once so the new reload value is in use
    repeat (160) @(posedge core_clk);
    wr(ADDR_DATA, 8'h3c);
    peer.recv_frame(8, 64, f);
    check("mode1 internal", f, {2'h1, 8'h3c, 1'h0});
    check("irq masked", irq, 1'h0);
    rdchk("irq status", ADDR_IRQ_STATUS, 8'h02);
    wr(ADDR_RELOAD_HIGH, 8'hff);
    wr(ADDR_RELOAD_LOW, 8'hfe);
    rdchk("reload high", ADDR_RELOAD_HIGH, 8'hff);
    wr(ADDR_DATA, 8'h5a);
    peer.recv_frame(8, 128, f);
    check("mode1 reload", f, {2'h1, 8'h5a, 1'h0});
    wr(ADDR_IRQ_STATUS, 8'h03);
    $display("test mode1 internal rate done");
  endtask

  task automatic t_mode1_timer;
    logic [10:0] f;
    wr(ADDR_BAUD_SELECT, 8'h00);
    wr(ADDR_BAUD_DOUBLE, 8'h80);
    ovfRun <= 1'h1;
    wr(ADDR_CONTROL, 8'h50);
    wr(ADDR_DATA, 8'hc3);
    peer.recv_frame(8, 64, f);
    check("mode1 timer", f, {2'h1, 8'hc3, 1'h0});
    peer.send_frame({2'h1, 8'h81, 1'h0}, 8, 64);
    rdchk("mode1 rx flags", ADDR_CONTROL, 8'h57);
    rdchk("mode1 rx buffer", ADDR_DATA, 8'h81);
    wr(ADDR_CONTROL, 8'hc8);
    wr(ADDR_DATA, 8'h5a);
    peer.recv_frame(9, 64, f);
    check("mode3 timer", f, {1'h1, 1'h1, 8'h5a, 1'h0});
    ovfRun <= 1'h0;
    wr(ADDR_CONTROL, 8'h00);
    $display("test mode1 timer rate done");
  endtask

  task automatic t_mode0;
    logic [7:0] d;
    logic prev;
    int k;
    int last;
    int per;
    d = 'x;
    k = 0;
    last = 0;
    per = 0;
    wr(ADDR_DATA, 8'h96);
    prev = txdOut;
    for (int c = 0; c < 300 && k < 8; c++) begin
      @(posedge core_clk);
      #1;
      if (prev === 1'h0 && txdOut === 1'h1) begin
        d[k] = rxdOut;
        if (k == 0) begin
          check("mode0 drive", rxdOe, 1'h1);
        end
        if (k == 1) begin
          per = c - last;
        end
        last = c;
        k++;
      end
      prev = txdOut;
    end
    check("mode0 data", d, 8'h96);
    check("mode0 period", 16'(per), 16'h000c);
    repeat (12) @(posedge core_clk);
    rdchk("mode0 tx done", ADDR_CONTROL, 8'h02);
    $display("test mode0 transmit done");
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'h1;
    t_regs();
    t_mode2_tx();
    t_mode2_rx();
    t_mode1_int();
    t_mode1_timer();
    t_mode0();
    tally_and_finish();
  end
endmodule
